// ### core/llpm_top.sv
// light-load pulse mode controller: fixed-frequency pwm or adaptive on-time light load
// assumes comparator and pin inputs are asynchronous, codes come from clk_sys logic
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
// Contract
// - in analog mode light load is allowed only while the select pin is above 4 v.
// - in digital mode light load is allowed only when the enable command bit is set.
// - shortly after the ramp ends the error-amplifier code is sampled and held for the dac.
// - light load is never entered before a calibration sample is held.
// - fixed mode goes to light load after a zero crossing in 8 consecutive cycles.
// - in light load a constant-width high-side pulse is followed by low side until zero current.
// - after zero current both switches stay off until the output falls to the reference.
// - if the reference is reached while current is positive the pulse waits for zero current.
// - light load ends when the output drops to 95 percent of the reference.
// - light load ends after 3 consecutive zero-current events with the output below reference.
// - tracking mode inhibits light load and keeps continuous conduction.
// - a new digital target inhibits light load until the ramp ends and a new sample is held.
// - tracking is selected by a grounded select pin, non-tracking by a pulled-up pin.
// - the regulation reference is the lower of the tracking input and the internal ramp.
// - after enable rises the internal reference ramps up to the 0.5 v target; in digital mode the code ramps to the target register instead.
module llpm_top import llpm_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // pins and comparators, asynchronous
   input wire logic enable_pin_on,
   input wire logic enable_light_load_select_pin,
   input wire logic track_select_pin_high,
   input wire logic zero_current,
   input wire logic vsense_below_ref,
   input wire logic vsense_below_95,
   input wire logic pwm_high_req,
   input wire logic pwm_low_req,
   input wire logic cycle_start,
   // codes from converters on clk_sys
   input wire logic [7:0] comp_code,
   input wire logic [7:0] external_tracking_input,
   // gate drives and reference outputs
   output logic high_side_gate,
   output logic low_side_gate,
   output logic adaptive_on_time_light_load,
   output logic [7:0] cal_dac_code,
   output logic [7:0] internal_reference_ramp,
   output logic [7:0] regulation_ref
);
   typedef struct packed {
      llpm_mode_t mode;
      logic ll_on;
      logic [3:0] zc_cnt;
      logic [1:0] below_cnt;
      logic zc_seen;
      logic zc_prev;
      logic cyc_prev;
      logic hs_prev;
      logic en_prev;
      logic [7:0] pw_meas;
      logic [7:0] pw_hold;
      logic [7:0] on_cnt;
      logic [7:0] ramp;
      logic ramping;
      logic [6:0] step_cnt;
      logic cal_wait;
      logic [6:0] cal_cnt;
      logic cal_start;
      logic cal_clear;
      logic hs;
      logic ls;
      logic [7:0] ref_out;
      logic digital_mode;
      logic ll_cmd;
      logic [7:0] target;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } llpm_state_t;
   llpm_state_t s_reg, s_next;

   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] syn;
   logic [7:0] cal_code;
   logic cal_valid;
   logic tracking;
   logic permit;
   logic zc_ev;
   logic cyc_ev;
   logic [7:0] ramp_goal;
   llpm_reg_t rsel;

   // map an apb byte address to a register
   function automatic llpm_reg_t reg_decode(input logic [7:0] addr);
      unique case (addr)
         OFF_CTRL: reg_decode = REG_CTRL;
         OFF_TARGET: reg_decode = REG_TARGET;
         OFF_STATUS: reg_decode = REG_STATUS;
         OFF_CAL: reg_decode = REG_CAL;
         OFF_REF: reg_decode = REG_REF;
         default: reg_decode = REG_NONE;
      endcase
   endfunction

   // gather asynchronous lanes
   always_comb begin
      raw_in = '0;
      raw_in[IN_EN] = enable_pin_on;
      raw_in[IN_LL_SEL] = enable_light_load_select_pin;
      raw_in[IN_TRACK_HI] = track_select_pin_high;
      raw_in[IN_ZC] = zero_current;
      raw_in[IN_BELOW_REF] = vsense_below_ref;
      raw_in[IN_BELOW_95] = vsense_below_95;
      raw_in[IN_PWM_HS] = pwm_high_req;
      raw_in[IN_PWM_LS] = pwm_low_req;
      raw_in[IN_CYCLE] = cycle_start;
   end

   llpm_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(raw_in),
      .sync_out(syn)
   );

   llpm_cal u_cal (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .capture(s_reg.cal_start),
      .clear(s_reg.cal_clear),
      .comp_code(comp_code),
      .cal_code(cal_code),
      .cal_valid(cal_valid)
   );

   // mode qualifiers and edge events
   always_comb begin
      tracking = !syn[IN_TRACK_HI];
      permit = (s_reg.digital_mode ? s_reg.ll_cmd : syn[IN_LL_SEL])
         && !tracking
         && cal_valid && !s_reg.ramping && !s_reg.cal_wait
         && syn[IN_EN];
      zc_ev = syn[IN_ZC] && !s_reg.zc_prev;
      cyc_ev = syn[IN_CYCLE] && !s_reg.cyc_prev;
      ramp_goal = s_reg.digital_mode ? s_reg.target : REF_0V5_CODE;
      rsel = reg_decode(paddr);
   end

   // next-state logic
   always_comb begin
      s_next = s_reg;
      s_next.zc_prev = syn[IN_ZC];
      s_next.cyc_prev = syn[IN_CYCLE];
      s_next.hs_prev = syn[IN_PWM_HS];
      s_next.en_prev = syn[IN_EN];
      s_next.cal_start = 1'b0;
      s_next.cal_clear = 1'b0;

      // reference ramp toward its goal
      if (!syn[IN_EN]) begin
         s_next.ramp = '0;
         s_next.ramping = 1'b0;
         s_next.cal_wait = 1'b0;
         s_next.cal_clear = 1'b1;
      end else if (syn[IN_EN] && !s_reg.en_prev) begin
         s_next.ramping = 1'b1;
         s_next.step_cnt = '0;
         s_next.cal_clear = 1'b1;
      end else if (s_reg.ramping) begin
         if (s_reg.step_cnt == RAMP_STEP_CNT - 7'h01) begin
            s_next.step_cnt = '0;
            if (s_reg.ramp < ramp_goal) begin
               s_next.ramp = s_reg.ramp + 8'h01;
            end else if (s_reg.ramp > ramp_goal) begin
               s_next.ramp = s_reg.ramp - 8'h01;
            end else begin
               s_next.ramping = 1'b0;
               s_next.cal_wait = 1'b1;
               s_next.cal_cnt = '0;
            end
         end else begin
            s_next.step_cnt = s_reg.step_cnt + 7'h01;
         end
      end else if (s_reg.cal_wait) begin
         if (s_reg.cal_cnt == CAL_DELAY_CNT - 7'h01) begin
            s_next.cal_wait = 1'b0;
            s_next.cal_start = 1'b1;
         end else begin
            s_next.cal_cnt = s_reg.cal_cnt + 7'h01;
         end
      end

      // lower of tracking input and internal ramp
      s_next.ref_out = (external_tracking_input < s_reg.ramp) ?
         external_tracking_input : s_reg.ramp;

      // measure the fixed-frequency high-side width for the adaptive on-time
      if (syn[IN_PWM_HS]) begin
         if (s_reg.pw_meas != 8'hFF) begin
            s_next.pw_meas = s_reg.pw_meas + 8'h01;
         end
      end else if (s_reg.hs_prev) begin
         s_next.pw_hold = (s_reg.pw_meas == 8'h00) ? 8'h01 : s_reg.pw_meas;
         s_next.pw_meas = '0;
      end

      // switching mode machine
      if (!permit) begin
         s_next.mode = MODE_FIXED;
         s_next.zc_cnt = '0;
         s_next.below_cnt = '0;
         s_next.zc_seen = 1'b0;
         s_next.hs = syn[IN_EN] && syn[IN_PWM_HS];
         s_next.ls = syn[IN_EN] && syn[IN_PWM_LS];
      end else begin
         unique case (s_reg.mode)
            MODE_FIXED: begin
               s_next.hs = syn[IN_PWM_HS];
               s_next.ls = syn[IN_PWM_LS];
               s_next.below_cnt = '0;
               // a crossing in the same cycle as the boundary still counts
               s_next.zc_seen = zc_ev || (s_reg.zc_seen && !cyc_ev);
               if (cyc_ev) begin
                  s_next.zc_seen = 1'b0;
                  if (s_reg.zc_seen || zc_ev) begin
                     s_next.zc_cnt = s_reg.zc_cnt + 4'h1;
                     if (s_reg.zc_cnt + 4'h1 == ZC_ENTRY_COUNT) begin
                        s_next.mode = MODE_LL_IDLE;
                        s_next.zc_cnt = '0;
                        s_next.hs = 1'b0;
                        s_next.ls = 1'b0;
                     end
                  end else begin
                     s_next.zc_cnt = '0;
                  end
               end
            end
            MODE_LL_ON: begin
               s_next.hs = 1'b1;
               s_next.ls = 1'b0;
               if (s_reg.on_cnt <= 8'h01) begin
                  s_next.mode = MODE_LL_LS;
                  s_next.hs = 1'b0;
                  s_next.ls = 1'b1;
               end else begin
                  s_next.on_cnt = s_reg.on_cnt - 8'h01;
               end
            end
            MODE_LL_LS: begin
               s_next.hs = 1'b0;
               s_next.ls = 1'b1;
               if (zc_ev) begin
                  s_next.ls = 1'b0;
                  if (syn[IN_BELOW_REF]) begin
                     s_next.below_cnt = s_reg.below_cnt + 2'h1;
                     if (s_reg.below_cnt + 2'h1 == BELOW_EXIT_COUNT) begin
                        s_next.mode = MODE_FIXED;
                        s_next.below_cnt = '0;
                     end else begin
                        s_next.mode = MODE_LL_ON;
                        s_next.on_cnt = s_reg.pw_hold;
                        s_next.hs = 1'b1;
                     end
                  end else begin
                     s_next.below_cnt = '0;
                     s_next.mode = MODE_LL_IDLE;
                  end
               end
            end
            MODE_LL_IDLE: begin
               s_next.hs = 1'b0;
               s_next.ls = 1'b0;
               if (syn[IN_BELOW_REF]) begin
                  s_next.mode = MODE_LL_ON;
                  s_next.on_cnt = s_reg.pw_hold;
                  s_next.hs = 1'b1;
               end
            end
         endcase
         // undervoltage exit overrides the light-load sequence
         if (s_reg.mode != MODE_FIXED && syn[IN_BELOW_95]) begin
            s_next.mode = MODE_FIXED;
            s_next.below_cnt = '0;
            s_next.zc_cnt = '0;
            s_next.hs = syn[IN_PWM_HS];
            s_next.ls = syn[IN_PWM_LS];
         end
      end

      s_next.ll_on = (s_next.mode != MODE_FIXED); // mode flag for the output pin

      // apb slave: one wait state, then completion
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
      if (psel && penable && !s_reg.pready) begin
         s_next.pready = 1'b1;
         s_next.pslverr = (rsel == REG_NONE);
         s_next.prdata = '0;
         if (!pwrite) begin
            unique case (rsel)
               REG_CTRL: begin
                  s_next.prdata[CTRL_DIGITAL_BIT] = s_reg.digital_mode;
                  s_next.prdata[CTRL_LL_CMD_BIT] = s_reg.ll_cmd;
               end
               REG_TARGET: s_next.prdata[7:0] = s_reg.target;
               REG_STATUS: begin
                  s_next.prdata[ST_LL_BIT] = (s_reg.mode != MODE_FIXED);
                  s_next.prdata[ST_CAL_BIT] = cal_valid;
                  s_next.prdata[ST_RAMP_BIT] = s_reg.ramping;
                  s_next.prdata[ST_TRACK_BIT] = tracking;
                  s_next.prdata[ST_PERMIT_BIT] = permit;
                  s_next.prdata[ST_ZC_LSB +: 4] = s_reg.zc_cnt;
                  s_next.prdata[ST_BELOW_LSB +: 2] = s_reg.below_cnt;
               end
               REG_CAL: s_next.prdata[7:0] = cal_code;
               REG_REF: s_next.prdata[7:0] = s_reg.ref_out;
               REG_NONE: s_next.prdata = '0;
            endcase
         end
      end
      // writes take effect at the completing edge
      if (psel && penable && s_reg.pready && pwrite) begin
         if (rsel == REG_CTRL) begin
            s_next.digital_mode = pwdata[CTRL_DIGITAL_BIT];
            s_next.ll_cmd = pwdata[CTRL_LL_CMD_BIT];
         end
         if (rsel == REG_TARGET) begin
            s_next.target = pwdata[7:0];
            if (s_reg.digital_mode && syn[IN_EN]) begin
               s_next.ramping = 1'b1;
               s_next.cal_wait = 1'b0;
               s_next.step_cnt = '0;
               s_next.cal_clear = 1'b1;
               s_next.cal_start = 1'b0;
            end
         end
      end
   end

   // register state
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.mode <= MODE_FIXED;
         s_reg.digital_mode <= CTRL_DIGITAL_RST;
         s_reg.ll_cmd <= CTRL_LL_CMD_RST;
         s_reg.target <= REF_0V5_CODE;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from flops
   assign pready = s_reg.pready;
   assign prdata = s_reg.prdata;
   assign pslverr = s_reg.pslverr;
   assign high_side_gate = s_reg.hs;
   assign low_side_gate = s_reg.ls;
   assign adaptive_on_time_light_load = s_reg.ll_on;
   assign cal_dac_code = cal_code;
   assign internal_reference_ramp = s_reg.ramp;
   assign regulation_ref = s_reg.ref_out;
endmodule

// ### core/llpm_pkg.sv
// constants and types for the light-load pulse mode controller
// assumes a 50 MHz system clock and a 32-bit apb register bus
package llpm_pkg;
   // clock rate
   localparam int CLK_MHZ = 50;
   // delay from ramp end to calibration capture, ns
   localparam int CAL_DELAY_NS = 1000;
   localparam int CAL_DELAY_CYC = (CAL_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam logic [6:0] CAL_DELAY_CNT = 7'(CAL_DELAY_CYC);
   // time per reference ramp step, ns
   localparam int RAMP_STEP_NS = 2000;
   localparam int RAMP_STEP_CYC = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [6:0] RAMP_STEP_CNT = 7'(RAMP_STEP_CYC);
   // mode entry and exit counts
   localparam logic [3:0] ZC_ENTRY_COUNT = 4'h8;
   localparam logic [1:0] BELOW_EXIT_COUNT = 2'h3;
   // reference code meaning 0.5 v
   localparam logic [7:0] REF_0V5_CODE = 8'h80;
   // apb byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TARGET = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_CAL = 8'h0C;
   localparam logic [7:0] OFF_REF = 8'h10;
   // control field positions and reset values
   localparam int CTRL_DIGITAL_BIT = 0;
   localparam int CTRL_LL_CMD_BIT = 1;
   localparam logic CTRL_DIGITAL_RST = 1'b0;
   localparam logic CTRL_LL_CMD_RST = 1'b0;
   // status field positions
   localparam int ST_LL_BIT = 0;
   localparam int ST_CAL_BIT = 1;
   localparam int ST_RAMP_BIT = 2;
   localparam int ST_TRACK_BIT = 3;
   localparam int ST_PERMIT_BIT = 4;
   localparam int ST_ZC_LSB = 8;
   localparam int ST_BELOW_LSB = 12;
   // synchronised input lanes
   localparam int SYNC_W = 9;
   localparam int IN_EN = 0;
   localparam int IN_LL_SEL = 1;
   localparam int IN_TRACK_HI = 2;
   localparam int IN_ZC = 3;
   localparam int IN_BELOW_REF = 4;
   localparam int IN_BELOW_95 = 5;
   localparam int IN_PWM_HS = 6;
   localparam int IN_PWM_LS = 7;
   localparam int IN_CYCLE = 8;
   // register index after decode
   typedef enum logic [2:0] {REG_CTRL, REG_TARGET, REG_STATUS, REG_CAL, REG_REF,
      REG_NONE} llpm_reg_t;
   // switching mode
   typedef enum logic [1:0] {MODE_FIXED, MODE_LL_ON, MODE_LL_LS, MODE_LL_IDLE} llpm_mode_t;
endpackage

// ### core/llpm_sync.sv
// two-stage synchroniser for the comparator and pin inputs
// assumes every lane is asynchronous to clk_sys
`timescale 1ns/10ps
module llpm_sync import llpm_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // lanes
   input wire logic [SYNC_W-1:0] async_in,
   output logic [SYNC_W-1:0] sync_out
);
   typedef struct packed {
      logic [SYNC_W-1:0] stage1;
      logic [SYNC_W-1:0] stage2;
   } llpm_sync_state_t;
   llpm_sync_state_t s_reg, s_next;

   // stage one feeds only stage two
   always_comb begin
      s_next.stage1 = async_in;
      s_next.stage2 = s_reg.stage1;
   end

   // register state
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sync_out = s_reg.stage2;
endmodule

// ### core/llpm_cal.sv
// calibration hold register for the sampled error-amplifier code
// assumes capture and clear are one-cycle pulses on clk_sys
`timescale 1ns/10ps
module llpm_cal import llpm_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control
   input wire logic capture,
   input wire logic clear,
   input wire logic [7:0] comp_code,
   // held sample
   output logic [7:0] cal_code,
   output logic cal_valid
);
   typedef struct packed {
      logic [7:0] code;
      logic valid;
   } llpm_cal_state_t;
   llpm_cal_state_t s_reg, s_next;

   // capture wins over clear in the same cycle
   always_comb begin
      s_next = s_reg;
      if (clear) begin
         s_next.valid = 1'b0;
      end
      if (capture) begin
         s_next.code = comp_code;
         s_next.valid = 1'b1;
      end
   end

   // register state
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cal_code = s_reg.code;
   assign cal_valid = s_reg.valid;
endmodule

// ### test/llpm_sva.sv
// port assertions for the light-load pulse mode controller
// assumes it is bound to llpm_top and runs on clk_sys alone
`timescale 1ns/10ps
module llpm_sva import llpm_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // pins and comparators
   input wire logic enable_light_load_select_pin,
   input wire logic track_select_pin_high,
   input wire logic zero_current,
   input wire logic vsense_below_ref,
   input wire logic vsense_below_95,
   input wire logic [7:0] external_tracking_input,
   // gates and references
   input wire logic high_side_gate,
   input wire logic low_side_gate,
   input wire logic adaptive_on_time_light_load,
   input wire logic [7:0] internal_reference_ramp,
   input wire logic [7:0] regulation_ref
);
   logic dig_reg;
   logic cmd_reg;
   logic allow;
   logic [7:0] quiet_reg;
   wire logic ll = adaptive_on_time_light_load;
   wire logic hs = high_side_gate;
   wire logic ls = low_side_gate;
   // mirror of the control bits, cycles since the ramp code last moved
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dig_reg <= 1'b0;
         cmd_reg <= 1'b0;
         quiet_reg <= 8'h00;
      end else begin
         if (psel && penable && pready && pwrite && paddr == OFF_CTRL) begin
            dig_reg <= pwdata[CTRL_DIGITAL_BIT];
            cmd_reg <= pwdata[CTRL_LL_CMD_BIT];
         end
         if (!$stable(internal_reference_ramp)) quiet_reg <= 8'h00;
         else if (quiet_reg != 8'hFF) quiet_reg <= quiet_reg + 8'h01;
      end
   end
   // light load allowed by pin or by command
   assign allow = dig_reg ? cmd_reg : enable_light_load_select_pin;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_reset_idle: assert property ($rose(rst_n) |-> !ll && !hs && !ls)
      else $error("outputs active right after reset");
   chk_allow_gate: assert property ((!allow) [*7] |-> !ll)
      else $error("light load while not selected");
   chk_track_block: assert property ((!track_select_pin_high) [*7] |-> !ll)
      else $error("light load while tracking");
   chk_cal_first: assert property ($rose(ll) |-> quiet_reg > 8'h8C)
      else $error("light load entered before a settled sample");
   chk_entry_idle: assert property ($rose(ll) |-> !hs && !ls)
      else $error("light load entry with a gate on");
   chk_no_overlap: assert property (!(hs && ls))
      else $error("both gates on");
   chk_pulse_low: assert property (ll && $past(ll) && $fell(hs) |-> ls)
      else $error("no low side after the pulse");
   chk_hold_low: assert property ((!zero_current) [*4] ##0 (ll && ls) |=> ls || !ll)
      else $error("low side released before zero current");
   chk_idle_wait: assert property ((!vsense_below_ref) [*5] ##0 (ll && !hs && !ls)
      |=> !hs || !ll)
      else $error("pulse issued above the reference");
   chk_exit_95: assert property (vsense_below_95 [*3] ##0 ll |=> !ll)
      else $error("light load kept below 95 percent");
   chk_ref_min: assert property (regulation_ref ==
      ($past(external_tracking_input) < $past(internal_reference_ramp) ?
      $past(external_tracking_input) : $past(internal_reference_ramp)))
      else $error("regulation reference is not the lower input");
endmodule

// ### test/llpm_plant.sv
// behavioural power stage: inductor ripple, output voltage, fixed-frequency modulator
// assumes gates registered on clk_sys; the fixed-mode voltage loop is held at regulation
`timescale 1ns/10ps
module llpm_plant (
   // clock
   input wire logic clk_sys,
   // gates, mode and load level
   input wire logic high_side_gate,
   input wire logic low_side_gate,
   input wire logic adaptive_on_time_light_load,
   input wire logic [3:0] load,
   // comparators and modulator
   output logic zero_current,
   output logic vsense_below_ref,
   output logic vsense_below_95,
   output logic pwm_high_req,
   output logic pwm_low_req,
   output logic cycle_start
);
   int r = -24;
   int v = 1005;
   int ph = 0;
   int dc;
   // heavy load lifts the current floor above zero
   assign dc = load > 2 ? 40 : 0;
   // ripple current, diode emulation when both gates are off, output charge
   always @(posedge clk_sys) begin
      ph <= (ph == 19) ? 0 : ph + 1;
      if (!adaptive_on_time_light_load && ph == 19) r <= -24;
      else if (high_side_gate) r <= r + 12;
      else if (low_side_gate) r <= r - 3;
      else r <= (r > 3) ? r - 3 : 0;
      if (!adaptive_on_time_light_load) v <= 1005;
      else v <= v + ((r + dc > 0) ? 2 : 0) - int'(load);
   end
   // outputs change just after the edge
   assign zero_current = r + dc <= 0;
   assign vsense_below_ref = v < 1000;
   assign vsense_below_95 = v < 950;
   assign pwm_high_req = ph < 4;
   assign pwm_low_req = ph >= 4;
   assign cycle_start = ph < 2;
endmodule

// ### test/light_load_pulse_mode_control_test.sv
// self-checking bench for the light-load pulse mode controller
// assumes llpm_top, llpm_plant and llpm_sva are compiled before it
`timescale 1ns/10ps
module light_load_pulse_mode_control_test import llpm_pkg::*;;
   logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, comp_code = 8'h00, external_tracking_input = 8'hFF;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, enable_pin_on = 1'b0, track_select_pin_high = 1'b1;
   logic enable_light_load_select_pin = 1'b1, high_side_gate, low_side_gate;
   logic adaptive_on_time_light_load, zero_current, vsense_below_ref, vsense_below_95;
   logic pwm_high_req, pwm_low_req, cycle_start;
   logic [7:0] cal_dac_code, internal_reference_ramp, regulation_ref;
   logic [3:0] load = 4'h1;
   int err_total = 0, total_checks = 0, seed = 49700, pw = 0, ctrl_m = 0, tgt_m = 0;
   wire logic ll = adaptive_on_time_light_load;
   always #10 clk_sys = ~clk_sys;
   llpm_top dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .enable_pin_on, .enable_light_load_select_pin, .track_select_pin_high,
      .zero_current, .vsense_below_ref, .vsense_below_95, .pwm_high_req, .pwm_low_req,
      .cycle_start, .comp_code, .external_tracking_input, .high_side_gate, .low_side_gate,
      .adaptive_on_time_light_load, .cal_dac_code, .internal_reference_ramp, .regulation_ref);
   llpm_plant plant (.clk_sys, .high_side_gate, .low_side_gate, .adaptive_on_time_light_load,
      .load, .zero_current, .vsense_below_ref, .vsense_below_95, .pwm_high_req, .pwm_low_req,
      .cycle_start);
   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask
   // verdict and end of run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) begin
            err_total++;
            end_of_test();
         end
         @(posedge clk_sys);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   // read with expected data and error flag
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
      check(err, e);
   endtask
   // bounded wait for a mode level
   task automatic wait_ll(input logic v, input int lim);
      int n;
      n = 0;
      while (ll !== v) begin
         n++;
         if (n > lim) begin
            err_total++;
            end_of_test();
         end
         @(posedge clk_sys);
      end
      check(ll, v);
   endtask
   // mode must still be at the given level at the end of a stretch
   task automatic hold(input logic v, input int cyc);
      repeat (cyc) @(posedge clk_sys);
      check(ll, v);
   endtask
   // each light-load pulse lasts the fixed-mode width of four cycles
   always @(posedge clk_sys) begin
      if (high_side_gate && ll) pw <= pw + 1;
      else begin
         if (pw > 0 && ll) check(pw, 4);
         pw <= 0;
      end
   end
   // main sequence
   initial begin
      comp_code <= 8'($random(seed));
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rdchk(OFF_CTRL, 32'h0, 1'b0);
      rdchk(OFF_TARGET, 32'h80, 1'b0);
      rdchk(OFF_STATUS, 32'h0, 1'b0);
      rdchk(8'h14, 32'h0, 1'b1);
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      check(err, 1'b1);
      tgt_m = $random(seed) & 8'hFF;
      apb(1'b1, OFF_TARGET, tgt_m);
      rdchk(OFF_TARGET, tgt_m, 1'b0);
      apb(1'b1, OFF_TARGET, 32'h80);
      enable_pin_on <= 1'b1;
      wait_ll(1'b1, 20000);
      check(internal_reference_ramp, REF_0V5_CODE);
      check(regulation_ref, REF_0V5_CODE);
      check(cal_dac_code, comp_code);
      apb(1'b1, OFF_CAL, ~comp_code);
      rdchk(OFF_CAL, comp_code, 1'b0);
      hold(1'b1, 1000);
      external_tracking_input <= 8'h40;
      repeat (3) @(posedge clk_sys);
      check(regulation_ref, 8'h40);
      external_tracking_input <= 8'hFF;
      load <= 4'h5;
      wait_ll(1'b0, 200);
      hold(1'b0, 500);
      load <= 4'h2;
      wait_ll(1'b1, 1000);
      wait_ll(1'b0, 300);
      load <= 4'h1;
      wait_ll(1'b1, 1000);
      track_select_pin_high <= 1'b0;
      wait_ll(1'b0, 20);
      hold(1'b0, 500);
      track_select_pin_high <= 1'b1;
      wait_ll(1'b1, 1000);
      enable_light_load_select_pin <= 1'b0;
      wait_ll(1'b0, 20);
      hold(1'b0, 500);
      ctrl_m = 1;
      apb(1'b1, OFF_CTRL, ctrl_m);
      enable_light_load_select_pin <= 1'b1;
      hold(1'b0, 500);
      rdchk(OFF_CTRL, ctrl_m, 1'b0);
      apb(1'b1, OFF_CTRL, 32'h3);
      wait_ll(1'b1, 1000);
      comp_code <= 8'($random(seed));
      apb(1'b1, OFF_TARGET, 32'h7E);
      wait_ll(1'b0, 10);
      wait_ll(1'b1, 3000);
      check(internal_reference_ramp, 8'h7E);
      check(cal_dac_code, comp_code);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check({ll, high_side_gate, low_side_gate}, 3'h0);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rdchk(OFF_CTRL, 32'h0, 1'b0);
      end_of_test();
   end
endmodule
bind llpm_top llpm_sva chk (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .enable_light_load_select_pin, .track_select_pin_high, .zero_current,
   .vsense_below_ref, .vsense_below_95, .external_tracking_input, .high_side_gate,
   .low_side_gate, .adaptive_on_time_light_load, .internal_reference_ramp, .regulation_ref);
